// ### shared/irq_ctl_defines.svh
// Constants for the two-level interrupt controller: offsets, fields, resets, timing.
// Assumes inclusion by bare name from both the package and the design.
`ifndef IRQ_CTL_DEFINES_SVH
`define IRQ_CTL_DEFINES_SVH

// Source count and field positions.
`define IC_SRC_MAX 15
`define IC_PRIM_SRCS 7
`define IC_GIE_BIT 7

// Register byte offsets on the AXI4-Lite bus.
`define IC_OFF_PRIM_EN 8'h00
`define IC_OFF_EXT_EN 8'h04
`define IC_OFF_PRIM_PRI 8'h08
`define IC_OFF_EXT_PRI 8'h0c
`define IC_OFF_PEND 8'h10
`define IC_OFF_STATUS 8'h14

// Status register field positions.
`define IC_ST_BUSY_BIT 4
`define IC_ST_HOLD_BIT 5
`define IC_ST_ACTLO_BIT 6
`define IC_ST_ACTHI_BIT 7

// Reset values.
`define IC_RST_SRC 15'h0000
`define IC_RST_VEC 16'h0000

// Vectoring: detect takes one cycle, the long call four.
`define IC_CALL_CYCLES 4
`define IC_CALL_LAST 3'h3
`define IC_VEC_BASE 16'h0003

// AXI responses.
`define IC_RESP_OKAY 2'b00
`define IC_RESP_SLVERR 2'b10

`endif

// ### shared/irq_ctl_pkg.sv
// Types for the two-level interrupt controller.
// Assumes irq_ctl_defines.svh is on the include path.
`include "irq_ctl_defines.svh"

package irq_ctl_pkg;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALL = 2'b01
  } seq_state_e;

  // Whole state of the controller.
  typedef struct packed {
    seq_state_e st;
    logic [2:0] cnt;
    logic [3:0] src;
    logic [15:0] vec;
    logic [`IC_SRC_MAX-1:0] pend;
    logic [`IC_SRC_MAX-1:0] en;
    logic [`IC_SRC_MAX-1:0] pri;
    logic gie;
    logic act_lo;
    logic act_hi;
    logic hold;
    logic req;
    logic req_hi;
    logic [3:0] req_src;
    logic aw_ok;
    logic [7:0] aw_addr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ctl_state_s;

endpackage

// ### design/irq_ctl.sv
// Two-level interrupt controller with AXI4-Lite register access.
// Assumes the core pulses instr_done at each instruction boundary and return_from_interrupt_done on return.
//
// Functional notes
// - A source's valid event sets its pending flag.
// - Flags set regardless of enable state.
// - Request raised when a flag is set and its source is enabled.
// - At instruction end, long call to the source's fixed vector.
// - Return resumes the interrupted program; the core handles this.
// - Disabled sources are ignored; no vectoring happens.
// - Each source has its own enable, effective only with global enable.
// - Global enable low blocks all requests.
// - Some flags are cleared by hardware when vectoring.
// - Other flags stay set until software clears them.
// - Flag still set after return re-enters after one more instruction.
// - Many sources, each assignable to one of two priority levels.
// - High preempts low; high never preempted; default low.
// - Higher level first; ties resolved by fixed source order.
// - Sampled every cycle; one detect plus four call cycles.
// - Software writing a flag to one requests like hardware.
`timescale 1ns/10ps
`include "irq_ctl_defines.svh"

module irq_ctl #(
  parameter int NUM_SRC = 15,
  parameter logic [`IC_SRC_MAX-1:0] AUTO_CLR_MASK = 15'h000f
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`IC_SRC_MAX-1:0] src_event,
  input wire logic instr_done,
  input wire logic return_from_interrupt_done,
  output logic irq_req,
  output logic long_call_busy,
  output logic [15:0] vector_addr,
  output logic [3:0] vector_src,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam logic [`IC_SRC_MAX-1:0] SRC_MASK = `IC_SRC_MAX'((1 << NUM_SRC) - 1);

  // Refuse source counts the register layout cannot hold.
  if (NUM_SRC <= `IC_PRIM_SRCS || NUM_SRC > `IC_SRC_MAX) begin : g_bad_num_src
    $error("NUM_SRC must lie between 8 and 15");
  end

  irq_ctl_pkg::ctl_state_s q;
  irq_ctl_pkg::ctl_state_s d;
  logic [`IC_SRC_MAX-1:0] src_ev_m;
  logic [`IC_SRC_MAX-1:0] elig;
  logic [`IC_SRC_MAX-1:0] hi_e;
  logic [`IC_SRC_MAX-1:0] lo_e;
  logic [`IC_SRC_MAX-1:0] sw_pend;
  logic [`IC_SRC_MAX-1:0] hw_clr;
  logic [`IC_SRC_MAX-1:0] pend_nx;
  logic [31:0] lane_m;
  logic [31:0] wr_val;
  logic [7:0] wr_off;
  logic do_wr;
  logic pend_wr;
  logic start_call;
  logic [3:0] hi_src;
  logic [3:0] lo_src;

  ////////////////////////////////////////////////////////////////////////////////
  // Request qualification and priority decode.

  // Only events of implemented sources count.
  assign src_ev_m = src_event & SRC_MASK;

  // A flag requests only when its own enable and the global enable are both set.
  assign elig = q.pend & q.en & {`IC_SRC_MAX{q.gie}};
  assign hi_e = elig & q.pri;
  assign lo_e = elig & ~q.pri;

  // Lowest source index wins within a level.
  always_comb begin
    hi_src = 4'h0;
    lo_src = 4'h0;
    for (int i = `IC_SRC_MAX - 1; i >= 0; i--) begin
      if (hi_e[i]) begin
        hi_src = 4'(i);
      end
      if (lo_e[i]) begin
        lo_src = 4'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register write path.

  // Byte lanes from the write strobes.
  assign lane_m = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}}, {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
  assign do_wr = q.aw_ok && q.w_ok && !q.bvalid;
  assign wr_off = {q.aw_addr[7:2], 2'b00};
  assign pend_wr = do_wr && (wr_off == `IC_OFF_PEND);
  assign wr_val = (32'(q.pend) & ~lane_m) | (q.wdata & lane_m);
  assign sw_pend = wr_val[`IC_SRC_MAX-1:0] & SRC_MASK;

  // Vectoring leaves the idle state at an instruction boundary, outside the re-entry hold.
  // The return itself is no further instruction, so it never vectors at its own edge.
  assign start_call = (q.st == irq_ctl_pkg::ST_IDLE) && q.req && instr_done && !q.hold &&
                      !return_from_interrupt_done;
  assign hw_clr = (start_call && AUTO_CLR_MASK[q.req_src]) ?
                  (`IC_SRC_MAX'(1) << q.req_src) : `IC_RST_SRC;

  ////////////////////////////////////////////////////////////////////////////////
  // Per-source pending flags: hardware set beats software write and hardware clear.

  for (genvar i = 0; i < `IC_SRC_MAX; i++) begin : g_pend
    assign pend_nx[i] = src_ev_m[i] ? 1'b1 :
                        pend_wr ? sw_pend[i] :
                        hw_clr[i] ? 1'b0 :
                        q.pend[i];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state for sequencer, registers and bus.

  always_comb begin
    d.st = q.st;
    d.pend = pend_nx;
    d.cnt = q.cnt;
    d.src = q.src;
    d.vec = q.vec;
    d.en = q.en;
    d.pri = q.pri;
    d.gie = q.gie;
    d.act_lo = q.act_lo;
    d.act_hi = q.act_hi;
    d.hold = q.hold;
    d.aw_ok = q.aw_ok;
    d.aw_addr = q.aw_addr;
    d.w_ok = q.w_ok;
    d.wdata = q.wdata;
    d.wstrb = q.wstrb;
    d.bvalid = q.bvalid;
    d.bresp = q.bresp;
    d.rvalid = q.rvalid;
    d.rdata = q.rdata;
    d.rresp = q.rresp;

    // Detect cycle: high requests unless a high routine runs; low only when none runs.
    d.req = (|hi_e && !q.act_hi) || (|lo_e && !q.act_lo && !q.act_hi);
    d.req_hi = |hi_e && !q.act_hi;
    d.req_src = d.req_hi ? hi_src : lo_src;

    // Long call sequence and return handling.
    unique case (q.st)
      irq_ctl_pkg::ST_IDLE: begin
        if (start_call) begin
          d.st = irq_ctl_pkg::ST_CALL;
          d.cnt = `IC_CALL_LAST;
          d.src = q.req_src;
          d.vec = `IC_VEC_BASE + {9'h000, q.req_src, 3'h0};
          if (q.req_hi) begin
            d.act_hi = 1'b1;
          end else begin
            d.act_lo = 1'b1;
          end
        end
      end
      irq_ctl_pkg::ST_CALL: begin
        d.cnt = q.cnt - 3'h1;
        if (q.cnt == 3'h0) begin
          d.st = irq_ctl_pkg::ST_IDLE;
        end
      end
    endcase

    // Return retires the running level and holds off re-entry for one instruction.
    if (return_from_interrupt_done) begin
      if (q.act_hi) begin
        d.act_hi = 1'b0;
      end else begin
        d.act_lo = 1'b0;
      end
      d.hold = 1'b1;
    end else if (instr_done) begin
      d.hold = 1'b0;
    end

    // Write address and data are taken independently.
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_ok = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_ok = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end

    // Register update once both halves are held.
    if (do_wr) begin
      d.aw_ok = 1'b0;
      d.w_ok = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `IC_RESP_OKAY;
      unique case (wr_off)
        `IC_OFF_PRIM_EN: begin
          d.gie = wr_val[`IC_GIE_BIT];
          d.en[`IC_PRIM_SRCS-1:0] = wr_val[`IC_PRIM_SRCS-1:0];
        end
        `IC_OFF_EXT_EN: begin
          d.en[`IC_SRC_MAX-1:`IC_PRIM_SRCS] = wr_val[7:0] & SRC_MASK[`IC_SRC_MAX-1:`IC_PRIM_SRCS];
        end
        `IC_OFF_PRIM_PRI: begin
          d.pri[`IC_PRIM_SRCS-1:0] = wr_val[`IC_PRIM_SRCS-1:0];
        end
        `IC_OFF_EXT_PRI: begin
          d.pri[`IC_SRC_MAX-1:`IC_PRIM_SRCS] = wr_val[7:0] & SRC_MASK[`IC_SRC_MAX-1:`IC_PRIM_SRCS];
        end
        `IC_OFF_PEND, `IC_OFF_STATUS: begin
        end
        default: begin
          d.bresp = `IC_RESP_SLVERR;
        end
      endcase
    end else if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // Reads answer one cycle after the address is taken.
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp = `IC_RESP_OKAY;
      d.rdata = 32'h0000_0000;
      unique case ({s_axi_araddr[7:2], 2'b00})
        `IC_OFF_PRIM_EN: begin
          d.rdata[`IC_GIE_BIT] = q.gie;
          d.rdata[`IC_PRIM_SRCS-1:0] = q.en[`IC_PRIM_SRCS-1:0];
        end
        `IC_OFF_EXT_EN: d.rdata[7:0] = 8'(q.en[`IC_SRC_MAX-1:`IC_PRIM_SRCS]);
        `IC_OFF_PRIM_PRI: d.rdata[`IC_PRIM_SRCS-1:0] = q.pri[`IC_PRIM_SRCS-1:0];
        `IC_OFF_EXT_PRI: d.rdata[7:0] = 8'(q.pri[`IC_SRC_MAX-1:`IC_PRIM_SRCS]);
        `IC_OFF_PEND: d.rdata[`IC_SRC_MAX-1:0] = q.pend;
        `IC_OFF_STATUS: begin
          d.rdata[3:0] = q.src;
          d.rdata[`IC_ST_BUSY_BIT] = (q.st == irq_ctl_pkg::ST_CALL);
          d.rdata[`IC_ST_HOLD_BIT] = q.hold;
          d.rdata[`IC_ST_ACTLO_BIT] = q.act_lo;
          d.rdata[`IC_ST_ACTHI_BIT] = q.act_hi;
        end
        default: d.rresp = `IC_RESP_SLVERR;
      endcase
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
  end

  // State register; all control comes out of reset idle, disabled and low priority.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Core-facing outputs come straight from the state register.
  assign irq_req = q.req;
  assign long_call_busy = (q.st == irq_ctl_pkg::ST_CALL);
  assign vector_addr = q.vec;
  assign vector_src = q.src;

  // Bus handshakes.
  assign s_axi_awready = !q.aw_ok && !q.bvalid;
  assign s_axi_wready = !q.w_ok && !q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  chk_event_sets_flag: assert property (@(posedge clk) disable iff (rst)
    (|src_ev_m) |=> ((q.pend & $past(src_ev_m)) == $past(src_ev_m)))
    else $error("event did not set its pending flag");

  chk_set_when_off: assert property (@(posedge clk) disable iff (rst)
    (!q.gie && src_ev_m[0]) |=> q.pend[0])
    else $error("flag of a disabled source not set");

  chk_req_raised: assert property (@(posedge clk) disable iff (rst)
    (|elig && !q.act_lo && !q.act_hi) |=> irq_req)
    else $error("enabled pending flag raised no request");

  chk_gie_blocks: assert property (@(posedge clk) disable iff (rst)
    (!q.gie) |=> !irq_req)
    else $error("request while global enable low");

  chk_off_ignored: assert property (@(posedge clk) disable iff (rst)
    ((q.en & q.pend) == `IC_RST_SRC) |=> !irq_req)
    else $error("disabled flag produced a request");

  chk_call_length: assert property (@(posedge clk) disable iff (rst)
    $rose(long_call_busy) |-> long_call_busy[*4] ##1 !long_call_busy)
    else $error("long call not four cycles");

  chk_call_start: assert property (@(posedge clk) disable iff (rst)
    start_call |=> (long_call_busy && vector_addr == `IC_VEC_BASE + {9'h000, vector_src, 3'h0}))
    else $error("vectoring did not start with the right address");

  chk_auto_clear: assert property (@(posedge clk) disable iff (rst)
    (start_call && AUTO_CLR_MASK[q.req_src] && !src_ev_m[q.req_src] && !pend_wr)
    |=> !q.pend[vector_src])
    else $error("auto-clear flag left set after vectoring");

  chk_return_from_interrupt_hold: assert property (@(posedge clk) disable iff (rst)
    (return_from_interrupt_done && q.st == irq_ctl_pkg::ST_IDLE) |=> !long_call_busy ##1 (q.hold || !long_call_busy))
    else $error("re-entry without one further instruction");

  chk_hi_no_preempt: assert property (@(posedge clk) disable iff (rst)
    $rose(long_call_busy) |-> !($past(q.act_hi)))
    else $error("high-priority routine preempted");

  chk_hw_wins: assert property (@(posedge clk) disable iff (rst)
    (pend_wr && src_ev_m[0] && !sw_pend[0]) |=> q.pend[0])
    else $error("software clear beat hardware set");

endmodule

// ### dv/core_model.sv
// Behavioural core: instruction boundaries and returns from service routines.
// Assumes long_call_busy from the controller and a one-cycle return request from the bench.
`timescale 1ns/10ps
module core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic long_call_busy,
  input wire logic slow,
  input wire logic return_from_interrupt_req,
  output logic instr_done,
  output logic return_from_interrupt_done
);
  logic [1:0] cnt_q;

  // An instruction ends each cycle, or every third when slow; none in the cycle after one with long_call_busy high.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 2'h0;
      instr_done <= 1'b0;
      return_from_interrupt_done <= 1'b0;
    end else begin
      cnt_q <= (slow && cnt_q != 2'h2) ? cnt_q + 2'h1 : 2'h0;
      instr_done <= !long_call_busy && (cnt_q == 2'h0);
      return_from_interrupt_done <= return_from_interrupt_req && !long_call_busy;
    end
  end
endmodule

// ### dv/two_level_interrupt_controller_tb.sv
// Self-checking bench for the two-level interrupt controller.
// Assumes the controller header on the include path and the core model beside it.
`timescale 1ns/10ps
`include "irq_ctl_defines.svh"
module two_level_interrupt_controller_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [14:0] src_event = 15'h0000;
  logic slow = 1'b0;
  logic return_from_interrupt_req = 1'b0;
  logic instr_done, return_from_interrupt_done, irq_req, long_call_busy;
  logic [15:0] vector_addr;
  logic [3:0] vector_src, s_axi_wstrb = 4'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] img [5] = '{5{32'h0}};
  logic [31:0] msk [5] = '{32'hff, 32'hff, 32'h7f, 32'hff, 32'h7fff};
  int num_errors = 0, checks = 0, seed = 16254, a;

  // Clock at 5 ns period.
  always #2.5 clk = ~clk;

  irq_ctl i_irq_ctl (.clk, .rst, .src_event, .instr_done, .return_from_interrupt_done, .irq_req, .long_call_busy,
    .vector_addr, .vector_src, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  core_model i_core_model (.clk, .rst, .long_call_busy, .slow, .return_from_interrupt_req, .instr_done, .return_from_interrupt_done);

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and hang handling.
  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", w, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic stop_hung(input string w);
    check(w, 32'h0, 32'h1);
    report_and_stop();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Bus master: every channel is sampled at the rising edge and changed just after it.
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic fin;
    logic [1:0] r;
    int n;
    fin = 1'b0;
    r = 2'b00;
    @(posedge clk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40 && !fin; n++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      fin = s_axi_bvalid === 1'b1;
      r = s_axi_bresp;
    end
    s_axi_bready <= 1'b0;
    if (!fin) stop_hung("write");
    check("bresp", r, er);
  endtask

  task automatic axi_rd(input logic [7:0] ad, output logic [31:0] d, input logic [1:0] er);
    logic fin;
    logic [1:0] r;
    int n;
    fin = 1'b0;
    r = 2'b00;
    d = 32'h0;
    @(posedge clk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40 && !fin; n++) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      fin = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      r = s_axi_rresp;
    end
    s_axi_rready <= 1'b0;
    if (!fin) stop_hung("read");
    check("rresp", r, er);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reference model: register images, lane-wise writes and the expected winner.
  task automatic reg_wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] lm;
    lm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    axi_wr(ad, d, s, `IC_RESP_OKAY);
    img[ad >> 2] = ((img[ad >> 2] & ~lm) | (d & lm)) & msk[ad >> 2];
  endtask

  function automatic int pick();
    logic [14:0] en, pri, rq;
    en = {img[1][7:0], img[0][6:0]};
    pri = {img[3][7:0], img[2][6:0]};
    rq = img[4][14:0] & en & {15{img[0][7]}};
    for (int i = 0; i < 15; i++) if (rq[i] && pri[i]) return i;
    for (int i = 0; i < 15; i++) if (rq[i]) return i;
    return -1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Core-side stimulus and call observation.
  task automatic pulse(input logic [14:0] m);
    @(posedge clk);
    src_event <= m;
    @(posedge clk);
    src_event <= 15'h0000;
    img[4][14:0] = img[4][14:0] | m;
  endtask

  task automatic return_from_interrupt();
    @(posedge clk);
    return_from_interrupt_req <= 1'b1;
    @(posedge clk);
    return_from_interrupt_req <= 1'b0;
  endtask

  task automatic quiet(input int c);
    repeat (c) begin
      @(posedge clk);
      #1;
      check("no_call", long_call_busy, 32'h0);
    end
  endtask

  // Latency counts edges after the event is sampled into its flag: one detects, one starts the call.
  task automatic wait_call(input int s, input int lat);
    int n, h;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (long_call_busy !== 1'b1 && n < 60);
    if (n == 60) stop_hung("call");
    if (lat > 0) check("latency", n, lat);
    check("vector_src", vector_src, s);
    check("vector_addr", vector_addr, 3 + 8 * s);
    for (h = 0; long_call_busy === 1'b1 && h < 9; h++) begin
      @(posedge clk);
      #1;
    end
    check("call_len", h, 4);
    if (s < 4) img[4][s] = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (a = 0; a < 6; a++) begin
      axi_rd(8'(a * 4), rd, `IC_RESP_OKAY);
      check("reset_val", rd, 32'h0);
    end
    axi_rd(8'h18, rd, `IC_RESP_SLVERR);
    check("unmapped", rd, 32'h0);
    axi_wr(8'h18, 32'hffffffff, 4'hf, `IC_RESP_SLVERR);
    for (a = 0; a < 5; a++) begin
      reg_wr(8'(a * 4), $random(seed), 4'($random(seed)));
      axi_rd(8'(a * 4), rd, `IC_RESP_OKAY);
      check("readback", rd, img[a]);
      reg_wr(8'(a * 4), 32'h0, 4'hf);
    end
    pulse(15'h0008);
    axi_rd(`IC_OFF_PEND, rd, `IC_RESP_OKAY);
    check("pend_dis", rd, img[4]);
    reg_wr(`IC_OFF_PRIM_EN, 32'h08, 4'h1);
    quiet(6);
    check("irq_req", irq_req, 32'h0);
    reg_wr(`IC_OFF_PRIM_EN, 32'h88, 4'h1);
    wait_call(pick(), 0);
    axi_rd(`IC_OFF_PEND, rd, `IC_RESP_OKAY);
    check("auto_clear", rd, img[4]);
    return_from_interrupt();
    pulse(15'h0008);
    wait_call(3, 2);
    return_from_interrupt();
    pulse(15'h0010);
    quiet(6);
    reg_wr(`IC_OFF_PRIM_EN, 32'ha8, 4'h1);
    pulse(15'h0020);
    wait_call(pick(), 0);
    axi_rd(`IC_OFF_PEND, rd, `IC_RESP_OKAY);
    check("pend_kept", rd, img[4]);
    return_from_interrupt();
    wait_call(pick(), 0);
    reg_wr(`IC_OFF_PEND, 32'h0, 4'h3);
    return_from_interrupt();
    quiet(8);
    reg_wr(`IC_OFF_PEND, 32'h20, 4'h1);
    wait_call(pick(), 0);
    reg_wr(`IC_OFF_PEND, 32'h0, 4'h1);
    return_from_interrupt();
    slow <= 1'b1;
    reg_wr(`IC_OFF_PRIM_EN, 32'h86, 4'h1);
    reg_wr(`IC_OFF_PEND, 32'h06, 4'h1);
    wait_call(pick(), 0);
    reg_wr(`IC_OFF_PEND, 32'h04, 4'h1);
    return_from_interrupt();
    wait_call(pick(), 0);
    reg_wr(`IC_OFF_PEND, 32'h0, 4'h1);
    return_from_interrupt();
    reg_wr(`IC_OFF_PRIM_PRI, 32'h04, 4'h1);
    reg_wr(`IC_OFF_PEND, 32'h06, 4'h1);
    wait_call(pick(), 0);
    reg_wr(`IC_OFF_PEND, 32'h02, 4'h1);
    quiet(8);
    return_from_interrupt();
    wait_call(pick(), 0);
    reg_wr(`IC_OFF_PEND, 32'h06, 4'h1);
    wait_call(pick(), 0);
    reg_wr(`IC_OFF_PEND, 32'h0, 4'h1);
    return_from_interrupt();
    return_from_interrupt();
    slow <= 1'b0;
    reg_wr(`IC_OFF_PRIM_EN, 32'h0, 4'h1);
    repeat (10) begin
      pulse(15'($random(seed)));
      axi_rd(`IC_OFF_PEND, rd, `IC_RESP_OKAY);
      check("pend_rand", rd, img[4]);
    end
    report_and_stop();
  end
endmodule
